// File: rtl/nfc_host_ctrl.sv
// Flash host controller: AXI4-Lite registers and flash command sequencer
`include "nfc_map.svh"
module nfc_host_ctrl #(
	parameter int AW = 24
) (
	input  wire logic          sys_clk_i,         // System clock
	input  wire logic          resetn_i,          // Async reset, active low
	input  wire logic [7:0]    s_axi_awaddr_i,    // Write address
	input  wire logic          s_axi_awvalid_i,   // Write address valid
	output logic               s_axi_awready_o,   // Write address ready
	input  wire logic [31:0]   s_axi_wdata_i,     // Write data
	input  wire logic [3:0]    s_axi_wstrb_i,     // Byte strobes
	input  wire logic          s_axi_wvalid_i,    // Write data valid
	output logic               s_axi_wready_o,    // Write data ready
	output logic [1:0]         s_axi_bresp_o,     // Write response
	output logic               s_axi_bvalid_o,    // Write response valid
	input  wire logic          s_axi_bready_i,    // Write response ready
	input  wire logic [7:0]    s_axi_araddr_i,    // Read address
	input  wire logic          s_axi_arvalid_i,   // Read address valid
	output logic               s_axi_arready_o,   // Read address ready
	output logic [31:0]        s_axi_rdata_o,     // Read data
	output logic [1:0]         s_axi_rresp_o,     // Read response
	output logic               s_axi_rvalid_o,    // Read data valid
	input  wire logic          s_axi_rready_i,    // Read data ready
	input  wire logic [15:0]   dq_i,              // Flash data in
	output logic [15:0]        dq_o,              // Flash data out
	output logic               dq_oe_o,           // Flash data driven
	output logic [AW-1:0]      flash_addr_o,      // Flash address
	output logic               chip_select_a_n_o, // Flash chip select
	output logic               oe_n_o,            // Flash output enable
	output logic               we_n_o,            // Flash write strobe
	output logic               reset_powerdown_n_o // Flash reset, active low
);
	logic        aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt, ar_rdy_r, ar_rdy_nxt;
	logic        bval_r, bval_nxt, rval_r, rval_nxt, go_r, go_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt, cfg_r, cfg_nxt;
	logic [7:0]  awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rdat_r, rdat_nxt, mw;
	logic [3:0]  ws_r, ws_nxt;
	logic [AW-1:0] addr_r, addr_nxt, cyc_addr;
	logic [15:0] wval_r, wval_nxt, rd_r, rd_nxt, cyc_data, pcfg_val, eng_rdata;
	logic [4:0]  cnt_r, cnt_nxt, idx_r, idx_nxt, n_lim, buf_idx;
	logic        wr_fire, busy, buf_we, start, cyc_wr, issued_r, issued_nxt, eng_done;
	logic        rpd_r, rpd_nxt;
	logic [9:0]  tmr_r, tmr_nxt;
	logic [15:0] buf_mem [32];
	nfc_pkg::nfc_op_e    op_r, op_nxt;
	nfc_pkg::nfc_state_e st_r, st_nxt;

	function automatic logic [31:0] merge32(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge32[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	function automatic logic [7:0] first_code(input nfc_pkg::nfc_op_e op);
		case (op)
			nfc_pkg::OP_RDARR:   first_code = `NFC_CMD_RDARR;
			nfc_pkg::OP_STATUS:  first_code = `NFC_CMD_RDSR;
			nfc_pkg::OP_CLRSR:   first_code = `NFC_CMD_CLRSR;
			nfc_pkg::OP_UNLOCK:  first_code = `NFC_CMD_LOCKCFG;
			nfc_pkg::OP_PAGECFG: first_code = `NFC_CMD_LOCKCFG;
			nfc_pkg::OP_PROG:    first_code = `NFC_CMD_PROG;
			default:             first_code = `NFC_CMD_BUFLOAD;
		endcase
	endfunction

	assign busy = st_r != nfc_pkg::S_IDLE;
	assign wr_fire = !aw_rdy_r && !w_rdy_r && !bval_r;
	assign mw = merge32(32'h0000_0000, wd_r, ws_r);
	assign n_lim = cfg_r[0] ? (cnt_r & `NFC_NMAX_WORD) : cnt_r;
	// only the eight-word bit may be set
	assign pcfg_val = 16'(cfg_r[1]) << `NFC_PCFG_8W_BIT;

	// ==========================================
	// AXI4-Lite slave and registers
	always_comb begin
		aw_rdy_nxt = aw_rdy_r;
		w_rdy_nxt = w_rdy_r;
		ar_rdy_nxt = ar_rdy_r;
		bval_nxt = bval_r;
		rval_nxt = rval_r;
		bresp_nxt = bresp_r;
		rresp_nxt = rresp_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		rdat_nxt = rdat_r;
		go_nxt = 1'b0;
		op_nxt = op_r;
		addr_nxt = addr_r;
		wval_nxt = wval_r;
		cnt_nxt = cnt_r;
		cfg_nxt = cfg_r;
		buf_we = 1'b0;
		buf_idx = awa_r[6:2];
		if (aw_rdy_r && s_axi_awvalid_i) begin
			aw_rdy_nxt = 1'b0;
			awa_nxt = s_axi_awaddr_i;
		end
		if (w_rdy_r && s_axi_wvalid_i) begin
			w_rdy_nxt = 1'b0;
			wd_nxt = s_axi_wdata_i;
			ws_nxt = s_axi_wstrb_i;
		end
		if (wr_fire) begin
			bval_nxt = 1'b1;
			bresp_nxt = `NFC_RESP_OKAY;
			// Settings are frozen while a flash sequence runs
			if (awa_r[7]) begin
				buf_we = !busy;
			end else begin
				case (awa_r)
					`NFC_OFS_CTRL: if (!busy && ws_r[0]) begin
						op_nxt = nfc_pkg::nfc_op_e'(wd_r[2:0]);
						go_nxt = 1'b1;
					end
					`NFC_OFS_ADDR: if (!busy) addr_nxt = AW'(merge32(32'(addr_r), wd_r, ws_r));
					`NFC_OFS_WDATA: if (!busy) wval_nxt = 16'(merge32(32'(wval_r), wd_r, ws_r));
					`NFC_OFS_COUNT: if (!busy) cnt_nxt = 5'(merge32(32'(cnt_r), wd_r, ws_r));
					`NFC_OFS_CFG: if (!busy) cfg_nxt = 2'(merge32(32'(cfg_r), wd_r, ws_r));
					`NFC_OFS_STATUS, `NFC_OFS_RDATA: ;
					default: bresp_nxt = `NFC_RESP_SLVERR;
				endcase
			end
		end
		if (bval_r && s_axi_bready_i) begin
			bval_nxt = 1'b0;
			aw_rdy_nxt = 1'b1;
			w_rdy_nxt = 1'b1;
		end
		if (ar_rdy_r && s_axi_arvalid_i) begin
			ar_rdy_nxt = 1'b0;
			rval_nxt = 1'b1;
			rresp_nxt = `NFC_RESP_OKAY;
			rdat_nxt = 32'h0000_0000;
			if (s_axi_araddr_i[7]) begin
				rdat_nxt = 32'(buf_mem[s_axi_araddr_i[6:2]]);
			end else begin
				case (s_axi_araddr_i)
					`NFC_OFS_CTRL:   rdat_nxt = 32'(op_r);
					`NFC_OFS_ADDR:   rdat_nxt = 32'(addr_r);
					`NFC_OFS_WDATA:  rdat_nxt = 32'(wval_r);
					`NFC_OFS_COUNT:  rdat_nxt = 32'(cnt_r);
					`NFC_OFS_STATUS: rdat_nxt = {22'h0, rpd_r, issued_r, st_r, 3'h0, busy};
					`NFC_OFS_RDATA:  rdat_nxt = 32'(rd_r);
					`NFC_OFS_CFG:    rdat_nxt = 32'(cfg_r);
					default:         rresp_nxt = `NFC_RESP_SLVERR;
				endcase
			end
		end
		if (rval_r && s_axi_rready_i) begin
			rval_nxt = 1'b0;
			ar_rdy_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
			ar_rdy_r <= 1'b1;
			bval_r <= 1'b0;
			rval_r <= 1'b0;
			bresp_r <= `NFC_RESP_OKAY;
			rresp_r <= `NFC_RESP_OKAY;
			awa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			rdat_r <= 32'h0000_0000;
			go_r <= 1'b0;
			op_r <= nfc_pkg::OP_RDARR;
			addr_r <= '0;
			wval_r <= 16'h0000;
			cnt_r <= 5'h00;
			cfg_r <= `NFC_CFG_RST;
		end else begin
			aw_rdy_r <= aw_rdy_nxt;
			w_rdy_r <= w_rdy_nxt;
			ar_rdy_r <= ar_rdy_nxt;
			bval_r <= bval_nxt;
			rval_r <= rval_nxt;
			bresp_r <= bresp_nxt;
			rresp_r <= rresp_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			rdat_r <= rdat_nxt;
			go_r <= go_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			wval_r <= wval_nxt;
			cnt_r <= cnt_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// Buffer has no reset: contents are only meaningful once written
	always_ff @(posedge sys_clk_i) begin
		if (buf_we) begin
			buf_mem[buf_idx] <= mw[15:0];
		end
	end

	assign s_axi_awready_o = aw_rdy_r;
	assign s_axi_wready_o = w_rdy_r;
	assign s_axi_bvalid_o = bval_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_arready_o = ar_rdy_r;
	assign s_axi_rvalid_o = rval_r;
	assign s_axi_rresp_o = rresp_r;
	assign s_axi_rdata_o = rdat_r;
	assign reset_powerdown_n_o = rpd_r;

	// ==========================================
	// Flash command sequencer
	always_comb begin
		st_nxt = st_r;
		issued_nxt = issued_r;
		idx_nxt = idx_r;
		tmr_nxt = tmr_r;
		rpd_nxt = rpd_r;
		rd_nxt = rd_r;
		cyc_wr = 1'b1;
		cyc_addr = addr_r;
		cyc_data = 16'h0000;
		case (st_r)
			nfc_pkg::S_CMD: begin
				cyc_data = 16'(first_code(op_r));
				if (op_r == nfc_pkg::OP_PAGECFG) cyc_addr = AW'(pcfg_val);
			end
			nfc_pkg::S_PC2: begin
				cyc_data = 16'(`NFC_CMD_PCFG);
				cyc_addr = AW'(pcfg_val);
			end
			nfc_pkg::S_PC3: cyc_data = 16'(`NFC_CMD_CLRSR);
			nfc_pkg::S_UNLK2, nfc_pkg::S_CONF: cyc_data = 16'(`NFC_CMD_CONFIRM);
			nfc_pkg::S_PDATA: cyc_data = wval_r;
			nfc_pkg::S_CNT: cyc_data = 16'(n_lim);
			nfc_pkg::S_DATA: begin
				cyc_data = buf_mem[idx_r];
				cyc_addr = addr_r + AW'(cfg_r[0] ? {idx_r, 1'b0} : {1'b0, idx_r});
			end
			nfc_pkg::S_XSR, nfc_pkg::S_POLL, nfc_pkg::S_READ: cyc_wr = 1'b0;
			default: ;
		endcase
		start = !issued_r && st_r != nfc_pkg::S_IDLE && st_r != nfc_pkg::S_RST;
		if (start) issued_nxt = 1'b1;
		case (st_r)
			nfc_pkg::S_IDLE: if (go_r) begin
				st_nxt = op_r == nfc_pkg::OP_READ ? nfc_pkg::S_READ : nfc_pkg::S_CMD;
			end
			// Hold the flash in reset, then release into array read
			nfc_pkg::S_RST: if (tmr_r == 10'h000) begin
				rpd_nxt = 1'b1;
				st_nxt = nfc_pkg::S_IDLE;
			end else begin
				tmr_nxt = tmr_r - 10'h001;
			end
			default: if (eng_done) begin
				issued_nxt = 1'b0;
				if (!cyc_wr) rd_nxt = eng_rdata;
				case (st_r)
					nfc_pkg::S_CMD: case (op_r)
						nfc_pkg::OP_STATUS:  st_nxt = nfc_pkg::S_READ;
						nfc_pkg::OP_UNLOCK:  st_nxt = nfc_pkg::S_UNLK2;
						nfc_pkg::OP_PAGECFG: st_nxt = nfc_pkg::S_PC2;
						nfc_pkg::OP_PROG:    st_nxt = nfc_pkg::S_PDATA;
						nfc_pkg::OP_BUFPROG: st_nxt = nfc_pkg::S_XSR;
						default:             st_nxt = nfc_pkg::S_IDLE;
					endcase
					nfc_pkg::S_PC2: st_nxt = cfg_r[1] ? nfc_pkg::S_PC3 : nfc_pkg::S_IDLE;
					nfc_pkg::S_XSR: st_nxt = eng_rdata[7] ? nfc_pkg::S_CNT : nfc_pkg::S_CMD;
					nfc_pkg::S_CNT: begin
						idx_nxt = 5'h00;
						st_nxt = nfc_pkg::S_DATA;
					end
					nfc_pkg::S_DATA: if (idx_r == n_lim) begin
						st_nxt = nfc_pkg::S_CONF;
					end else begin
						idx_nxt = idx_r + 5'h01;
					end
					nfc_pkg::S_UNLK2, nfc_pkg::S_PDATA, nfc_pkg::S_CONF: st_nxt = nfc_pkg::S_POLL;
					nfc_pkg::S_POLL: if (eng_rdata[7]) st_nxt = nfc_pkg::S_IDLE;
					default: st_nxt = nfc_pkg::S_IDLE;
				endcase
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= nfc_pkg::S_RST;
			issued_r <= 1'b0;
			idx_r <= 5'h00;
			tmr_r <= 10'(`NFC_RST_CYC);
			rpd_r <= 1'b0;
			rd_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			issued_r <= issued_nxt;
			idx_r <= idx_nxt;
			tmr_r <= tmr_nxt;
			rpd_r <= rpd_nxt;
			rd_r <= rd_nxt;
		end
	end

	nfc_bus_cycle #(.AW(AW)) u_cyc (
		.sys_clk_i         (sys_clk_i),
		.resetn_i          (resetn_i),
		.start_i           (start),
		.write_i           (cyc_wr),
		.addr_i            (cyc_addr),
		.wdata_i           (cyc_data),
		.dq_i              (dq_i),
		.done_o            (eng_done),
		.rdata_o           (eng_rdata),
		.flash_addr_o      (flash_addr_o),
		.dq_o              (dq_o),
		.dq_oe_o           (dq_oe_o),
		.chip_select_a_n_o (chip_select_a_n_o),
		.oe_n_o            (oe_n_o),
		.we_n_o            (we_n_o)
	);

	// ==========================================
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_code_defined;
		start && cyc_wr && st_r inside {nfc_pkg::S_CMD, nfc_pkg::S_PC2, nfc_pkg::S_PC3,
			nfc_pkg::S_UNLK2, nfc_pkg::S_CONF} |-> cyc_data[15:8] == 8'h00 &&
			cyc_data[7:0] inside {`NFC_CMD_RDARR, `NFC_CMD_RDSR, `NFC_CMD_CLRSR,
			`NFC_CMD_LOCKCFG, `NFC_CMD_CONFIRM, `NFC_CMD_PROG, `NFC_CMD_BUFLOAD, `NFC_CMD_PCFG};
	endproperty
	a_code_defined: assert property (p_code_defined) else $error("undefined code");
	property p_count_range;
		start && st_r == nfc_pkg::S_CNT |->
			cyc_data <= 16'(cfg_r[0] ? `NFC_NMAX_WORD : `NFC_NMAX_BYTE);
	endproperty
	a_count_range: assert property (p_count_range) else $error("count out of range");
	property p_confirm_count;
		start && st_r == nfc_pkg::S_CONF |-> idx_r == n_lim && $past(st_r, 2) != nfc_pkg::S_CNT;
	endproperty
	a_confirm_count: assert property (p_confirm_count) else $error("confirm early");
	property p_avail_first;
		st_r == nfc_pkg::S_CNT && $past(st_r) != nfc_pkg::S_CNT |->
			$past(st_r) == nfc_pkg::S_XSR && rd_r[7];
	endproperty
	a_avail_first: assert property (p_avail_first) else $error("buffer not free");
	property p_pcfg_reserved;
		start && (st_r == nfc_pkg::S_PC2 || (st_r == nfc_pkg::S_CMD &&
			op_r == nfc_pkg::OP_PAGECFG)) |-> cyc_addr[15:0] == pcfg_val &&
			(cyc_addr[15:0] & ~(16'h0001 << `NFC_PCFG_8W_BIT)) == 16'h0000;
	endproperty
	a_pcfg_reserved: assert property (p_pcfg_reserved) else $error("reserved bit set");
	property p_pcfg_seq;
		st_r == nfc_pkg::S_CMD && op_r == nfc_pkg::OP_PAGECFG && eng_done |=>
			start && st_r == nfc_pkg::S_PC2 && cyc_data == 16'(`NFC_CMD_PCFG);
	endproperty
	a_pcfg_seq: assert property (p_pcfg_seq) else $error("config confirm missing");
	property p_pcfg_clear;
		st_r == nfc_pkg::S_PC2 && eng_done && cfg_r[1] |=>
			start && cyc_data == 16'(`NFC_CMD_CLRSR) ##1 issued_r[*2];
	endproperty
	a_pcfg_clear: assert property (p_pcfg_clear) else $error("status clear missing");

	c_bufprog: cover property (start && st_r == nfc_pkg::S_CONF);
	c_pcfg8: cover property (start && st_r == nfc_pkg::S_PC3);
	c_unlock: cover property (start && st_r == nfc_pkg::S_UNLK2);
	c_xsr_retry: cover property (st_r == nfc_pkg::S_XSR && eng_done && !eng_rdata[7]);
endmodule // nfc_host_ctrl

// File: pkg/nfc_map.svh
// Register offsets, flash command codes and timing counts of the flash host controller
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH
// Function
// - Host issues only defined command codes; other codes are reserved.
// - Count N gives N+1 data writes; N up to 1F byte, 0F word.
// - Exactly N+1 data writes, then confirm 0xD0; anything else aborts.
// - After buffer-load command, host polls availability until a buffer is free.
// - Flash drives data only when selected and output enabled; write strobe high.
// - Host writes zero to every reserved page configuration bit.
// - Page configuration set: 0x60 then 0x04, value on A[15:0].
// - For eight-word mode the host follows with status-clear 0x50.
`define NFC_CLK_MHZ       25
`define NFC_T_WP_NS       70
`define NFC_T_ACC_NS      125
`define NFC_T_RST_NS      25000
`define NFC_WR_CYC        ((`NFC_T_WP_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_RD_CYC        ((`NFC_T_ACC_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_RST_CYC       ((`NFC_T_RST_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_SYNC_LAT      2
`define NFC_OFS_CTRL      8'h00
`define NFC_OFS_ADDR      8'h04
`define NFC_OFS_WDATA     8'h08
`define NFC_OFS_COUNT     8'h0C
`define NFC_OFS_STATUS    8'h10
`define NFC_OFS_RDATA     8'h14
`define NFC_OFS_CFG       8'h18
`define NFC_CFG_RST       2'h1
`define NFC_PCFG_8W_BIT   13
`define NFC_CMD_RDARR     8'hFF
`define NFC_CMD_RDSR      8'h70
`define NFC_CMD_CLRSR     8'h50
`define NFC_CMD_LOCKCFG   8'h60
`define NFC_CMD_CONFIRM   8'hD0
`define NFC_CMD_PROG      8'h40
`define NFC_CMD_BUFLOAD   8'hE8
`define NFC_CMD_PCFG      8'h04
`define NFC_NMAX_BYTE     5'h1F
`define NFC_NMAX_WORD     5'h0F
`define NFC_RESP_OKAY     2'h0
`define NFC_RESP_SLVERR   2'h2
`endif

// File: pkg/nfc_pkg.sv
// Types shared by the flash host controller modules
package nfc_pkg;
	typedef enum logic [2:0] {OP_RDARR, OP_READ, OP_STATUS, OP_CLRSR,
		OP_UNLOCK, OP_PAGECFG, OP_PROG, OP_BUFPROG} nfc_op_e;
	typedef enum logic [3:0] {S_IDLE, S_RST, S_CMD, S_PC2, S_PC3, S_UNLK2,
		S_PDATA, S_XSR, S_CNT, S_DATA, S_CONF, S_POLL, S_READ} nfc_state_e;
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} nfc_eng_e;
endpackage

// File: rtl/nfc_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, on the flash pins
`include "nfc_map.svh"
module nfc_bus_cycle #(
	parameter int AW = 24
) (
	input  wire logic          sys_clk_i,         // System clock
	input  wire logic          resetn_i,          // Async reset, active low
	input  wire logic          start_i,           // Start a cycle
	input  wire logic          write_i,           // 1 write, 0 read
	input  wire logic [AW-1:0] addr_i,            // Cycle address
	input  wire logic [15:0]   wdata_i,           // Write data
	input  wire logic [15:0]   dq_i,              // Data pins in
	output logic               done_o,            // Cycle finished pulse
	output logic [15:0]        rdata_o,           // Read data
	output logic [AW-1:0]      flash_addr_o,      // Address pins
	output logic [15:0]        dq_o,              // Data pins out
	output logic               dq_oe_o,           // Data pins driven
	output logic               chip_select_a_n_o, // Chip select
	output logic               oe_n_o,            // Output enable
	output logic               we_n_o             // Write strobe
);
	nfc_pkg::nfc_eng_e st_r, st_nxt;
	logic [3:0]    cnt_r, cnt_nxt;
	logic          wr_r, wr_nxt, done_nxt, oe_nxt, cs_nxt, oen_nxt, wen_nxt;
	logic [15:0]   rd_nxt, dq_nxt, s1_r, s2_r, s3_r;
	logic [AW-1:0] a_nxt;

	// ==========================================
	// Pin synchroniser
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
			s3_r <= 16'h0000;
		end else begin
			s1_r <= dq_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// ==========================================
	// Cycle sequencer
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		done_nxt = 1'b0;
		rd_nxt = rdata_o;
		a_nxt = flash_addr_o;
		dq_nxt = dq_o;
		oe_nxt = dq_oe_o;
		cs_nxt = chip_select_a_n_o;
		oen_nxt = oe_n_o;
		wen_nxt = we_n_o;
		case (st_r)
			nfc_pkg::E_IDLE: if (start_i) begin
				st_nxt = nfc_pkg::E_SETUP;
				a_nxt = addr_i;
				dq_nxt = write_i ? wdata_i : 16'h0000;
				oe_nxt = write_i;
				wr_nxt = write_i;
				cs_nxt = 1'b0;
			end
			nfc_pkg::E_SETUP: begin
				st_nxt = nfc_pkg::E_STROBE;
				// Read adds synchroniser latency to the access time
				cnt_nxt = wr_r ? 4'(`NFC_WR_CYC - 1) : 4'(`NFC_RD_CYC + `NFC_SYNC_LAT);
				wen_nxt = !wr_r;
				oen_nxt = wr_r;
			end
			nfc_pkg::E_STROBE: begin
				if (cnt_r != 4'h0) begin
					cnt_nxt = cnt_r - 4'h1;
				end else if (wr_r || s2_r == s3_r) begin
					if (!wr_r) begin
						rd_nxt = s3_r;
					end
					wen_nxt = 1'b1;
					oen_nxt = 1'b1;
					st_nxt = nfc_pkg::E_HOLD;
				end
			end
			nfc_pkg::E_HOLD: begin
				// Data held one cycle past the strobe edge
				cs_nxt = 1'b1;
				oe_nxt = 1'b0;
				done_nxt = 1'b1;
				st_nxt = nfc_pkg::E_IDLE;
			end
			default: st_nxt = nfc_pkg::E_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= nfc_pkg::E_IDLE;
			cnt_r <= 4'h0;
			wr_r <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0000;
			flash_addr_o <= '0;
			dq_o <= 16'h0000;
			dq_oe_o <= 1'b0;
			chip_select_a_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			done_o <= done_nxt;
			rdata_o <= rd_nxt;
			flash_addr_o <= a_nxt;
			dq_o <= dq_nxt;
			dq_oe_o <= oe_nxt;
			chip_select_a_n_o <= cs_nxt;
			oe_n_o <= oen_nxt;
			we_n_o <= wen_nxt;
		end
	end

	// ==========================================
	// Checks
	property p_read_no_write;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		!oe_n_o |-> we_n_o && !chip_select_a_n_o && !dq_oe_o;
	endproperty
	a_read_no_write: assert property (p_read_no_write) else $error("write strobe during read");
endmodule // nfc_bus_cycle

// File: sim/nfc_flash_mdl.sv
// Behavioural flash device seen from the controller pins
module nfc_flash_mdl (
	input  wire logic [23:0] addr_i, // Address pins
	input  wire logic [15:0] dq_i,   // Data from controller
	input  wire logic        cs_n_i, // Chip select, active low
	input  wire logic        oe_n_i, // Output enable, active low
	input  wire logic        we_n_i, // Write strobe, active low
	input  wire logic        rp_n_i, // Reset, active low
	output logic [15:0]      dq_o    // Data to controller
);
	timeunit 1ns;
	timeprecision 1ns;
	bit   [15:0] mem [64];
	logic [15:0] pc_r = 16'h0, ls_r = 16'h0;
	logic [7:0]  pv_r = 8'h0, c;
	logic [5:0]  lf_r = 6'h0;
	logic [1:0]  ph_r = 2'h0;
	logic        st_r = 1'b0, bz_r = 1'b0, lk_r = 1'b1;
	// ==========
	// Command decoding
	// reset defaults
	always @(negedge rp_n_i) {st_r, bz_r, lk_r, ph_r, pv_r, pc_r} = {3'h1, 2'h0, 8'h0, 16'h0};
	task automatic go;
		st_r = 1'b1;
		bz_r = 1'b1;
		bz_r <= #400 1'b0;
	endtask
	// latch at strobe end, low byte
	always @(posedge we_n_i) begin
		c = dq_i[7:0];
		if (ph_r == 2'h2) begin
			mem[addr_i[6:1]] = dq_i;
			lf_r = lf_r - 6'h1;
			if (lf_r == 6'h0) ph_r = 2'h3;
		end else if (ph_r == 2'h1) begin
			lf_r = {1'b0, dq_i[4:0]} + 6'h1;
			ph_r = 2'h2;
		end else if (ph_r == 2'h3) begin
			ph_r = 2'h0;
			if (c == 8'hD0) go();
		end else if (pv_r == 8'h60) begin
			if (c == 8'hD0) lk_r = 1'b0;
			if (c == 8'hD0) go();
			if (c == 8'h04) {st_r, pc_r} = {1'b0, addr_i[15:0]};
			pv_r = 8'h0;
		end else if (pv_r == 8'h40 || pv_r == 8'h10) begin
			mem[addr_i[6:1]] = dq_i;
			go();
			pv_r = 8'h0;
		end else begin
			pv_r = c;
			if (c == 8'hFF && !bz_r) st_r = 1'b0;
			if (c == 8'h70 || c == 8'hE8) st_r = 1'b1;
			if (c == 8'hE8) ph_r = 2'h1;
		end
	end
	// Released lines show a moving pattern, never the last value
	always @(posedge oe_n_i) ls_r = ls_r + 16'h1357;
	// drive when selected, busy gives D7 only
	assign dq_o = (cs_n_i | oe_n_i) ? ls_r : !st_r ? mem[addr_i[6:1]]
		: bz_r ? {ls_r[15:8], 1'b0, ls_r[6:0]} : 16'h0080;
endmodule // nfc_flash_mdl

// File: sim/nfc_host_ctrl_tb.sv
// Self-checking bench of the flash host controller
module nfc_host_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic [1:0] br, rr;
	logic awr, wrd, bv, arr, rv, oe, cs_n, oe_n, we_n, rp_n;
	logic [15:0] dqo, mq;
	logic [23:0] fa;
	wire logic [15:0] dqi = oe ? dqo : mq;
	int mismatches = 0, total_checks = 0;
	nfc_host_ctrl u_nfc_host_ctrl (.sys_clk_i(clk), .resetn_i(rstn), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
		.dq_i(dqi), .dq_o(dqo), .dq_oe_o(oe), .flash_addr_o(fa), .chip_select_a_n_o(cs_n),
		.oe_n_o(oe_n), .we_n_o(we_n), .reset_powerdown_n_o(rp_n));
	nfc_flash_mdl u_nfc_flash_mdl (.addr_i(fa), .dq_i(dqo), .cs_n_i(cs_n), .oe_n_i(oe_n),
		.we_n_i(we_n), .rp_n_i(rp_n), .dq_o(mq));
	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic logic [31:0] exp_pcfg(input logic eight);
		return eight ? 32'h2000 : 32'h0;
	endfunction
	task automatic guard(input int n);
		if (n >= 400) mismatches++;
		if (n >= 400) stop_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n = 0;
		@(posedge clk);
		{awa, wd, awv, wv, bre} <= {a, d, 3'h7};
		do begin
			@(posedge clk);
			n++;
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (bv !== 1'b1 && n < 400);
		bre <= 1'b0;
		guard(n);
		chk(br, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
		int n = 0;
		@(posedge clk);
		{ara, arv, rre} <= {a, 2'h3};
		do begin
			@(posedge clk);
			n++;
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1 && n < 400);
		d = rdat;
		rre <= 1'b0;
		guard(n);
		chk(rr, e);
	endtask
	task automatic idle;
		logic [31:0] s;
		int n = 0;
		do begin
			rd(8'h10, s, 2'h0);
			n++;
		end while (s[0] !== 1'b0 && n < 400);
		guard(n);
	endtask
	task automatic op(input logic [2:0] o);
		wr(8'h00, {29'h0, o}, 2'h0);
		idle();
	endtask
	initial forever #20 clk = ~clk;
	// ==========
	// Main sequence
	initial begin
		logic [31:0] v, d;
		logic [15:0] q [16];
		int m;
		void'($urandom(32'h917AAE4F));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h10, v, 2'h0);
		chk(v & 32'h201, 32'h1);
		idle();
		rd(8'h10, v, 2'h0);
		chk(v & 32'h201, 32'h200);
		rd(8'h18, v, 2'h0);
		chk(v, 32'h1);
		op(3'h2);
		rd(8'h14, v, 2'h0);
		chk(v & 32'hFF, 32'h80);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			d = $urandom & 32'hFFFF;
			wr(8'h04, $urandom & 32'h7E, 2'h0);
			wr(8'h08, d, 2'h0);
			op(3'h6);
			op(3'h0);
			op(3'h1);
			rd(8'h14, v, 2'h0);
			chk(v & 32'hFFFF, d);
		end
		$display("program test done");
		for (int k = 0; k < 2; k++) begin
			m = k ? $urandom_range(14, 0) : 15;
			for (int i = 0; i <= m; i++) q[i] = 16'($urandom);
			for (int i = 0; i <= m; i++) wr(8'h80 + 8'(4 * i), {16'h0, q[i]}, 2'h0);
			wr(8'h0C, m, 2'h0);
			wr(8'h04, 32'h0, 2'h0);
			op(3'h7);
			for (int i = 0; i <= m; i++) chk(u_nfc_flash_mdl.mem[i], q[i]);
		end
		$display("buffer test done");
		op(3'h4);
		chk(u_nfc_flash_mdl.lk_r, 1'b0);
		op(3'h3);
		op(3'h2);
		rd(8'h14, v, 2'h0);
		chk(v & 32'hFF, 32'h80);
		wr(8'h18, 32'h3, 2'h0);
		op(3'h5);
		chk(u_nfc_flash_mdl.pc_r, exp_pcfg(1'b1));
		chk(u_nfc_flash_mdl.st_r, 1'b0);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		idle();
		chk(u_nfc_flash_mdl.pc_r, exp_pcfg(1'b0));
		rd(8'h18, v, 2'h0);
		chk(v, 32'h1);
		wr(8'h40, $urandom, 2'h2);
		rd(8'h44, v, 2'h2);
		chk(v, 32'h0);
		$display("config test done");
		stop_test();
	end
endmodule // nfc_host_ctrl_tb
